/* core/mts_pkg.sv */
package mts_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets on the APB slave)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_INSTR = 12'h004;
    localparam logic [11:0] OFF_IADDR = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_FADDR = 12'h010;
    localparam logic [11:0] OFF_FCAUSE = 12'h014;
    localparam logic [11:0] OFF_ALINK = 12'h018;

    localparam int CTRL_START = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_ABORT = 2;
    localparam int STAT_BADOP = 3;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int BIT_P = 24;
    localparam int BIT_U = 23;
    localparam int BIT_S = 22;
    localparam int BIT_W = 21;
    localparam int BIT_L = 20;
    localparam int BIT_B = 22;
    localparam int BASE_HI = 19;
    localparam int BASE_LO = 16;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 12;
    localparam int SRC_HI = 3;
    localparam int SRC_LO = 0;
    localparam int LIST_HI = 15;
    localparam int CLASS_HI = 27;
    localparam int BLOCK_LO = 25;
    localparam int SWAP_LO = 23;
    localparam int MARK_HI = 7;
    localparam int MARK_LO = 4;

    localparam logic [2:0] BLOCK_CLASS = 3'h4;
    localparam logic [4:0] SWAP_CLASS = 5'h02;
    localparam logic [3:0] SWAP_MARK = 4'h9;
    localparam logic [3:0] PC_REG = 4'hf;

    // ------------------------------------------------------------
    // arithmetic and codes
    // ------------------------------------------------------------
    localparam logic [31:0] WORD_STEP = 32'h00000004;
    localparam logic [31:0] LINK_OFFSET = 32'h00000008;
    localparam logic [31:0] PC_STORE_OFFSET = 32'h0000000c;
    localparam logic [31:0] BYTE_MASK = 32'h000000ff;
    localparam logic [3:0] CAUSE_MMU = 4'h1;
    localparam logic [3:0] CAUSE_EXT = 4'h2;
    localparam logic [1:0] PC_EXTRA_FETCHES = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_XFER = 3'b010,
        ST_INTERNAL = 3'b011,
        ST_PCFETCH = 3'b100,
        ST_SWPRD = 3'b101,
        ST_SWPWR = 3'b110
    } state_e;

endpackage

/* core/multi_transfer_swap_sequencer.sv */
`timescale 1ns/10ps
// Functional notes
// (RL1) base write-back at end of cycle two
// (RL2) first store at cycle two; base value order-dependent
// (RL3) loaded base overrides written-back base
// (RL4) accept internal or external abort, then trap; an external abort in the last data cycle is lost unless pc is loaded
// (RL5) record fault address, cause, link plus 8
// (RL6) store-multiple completes before abort trap
// (RL7) aborted store changes only written-back base
// (RL8) outside controller blocks writes on external abort
// (RL9) abort suppresses current and later loads, a translation abort also the one before; an external abort lands late, its own load still written
// (RL10) program counter always loaded last
// (RL11) translation abort leaves the register loaded just before it unwritten; loads two or more transfers before the abort are still written
// (RL12) aborted load restores base, updated or original
// (RL13) load-multiple abort trap after sequence ends
// (RL14) cycle counts: fetch, n transfers, internal
// (RL15) pre and up flags choose four modes
// (RL16) status restore with pc, else user bank
// (RL17) swap read and write are inseparable
// (RL18) swap reads base address, writes source
// (RL19) bus lock high across swap read and write
// (RL20) memory manager keeps off while lock high
// (RL21) swap byte when flag set, else word
// (RL22) swap: fetch, read, write, internal
// (RL23) ascending register order, lowest address first
// (RL24) sixteen-bit list, bit i selects register
// (RL25) successive transfers step four bytes
module multi_transfer_swap_sequencer (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic privMode,
    output logic memReq,
    output logic memWrite,
    output logic memByte,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic [31:0] memRdata,
    input wire logic mmuAbort,
    input wire logic extAbort,
    output logic busLock,
    output logic intBlock,
    output logic fetchReq,
    output logic [3:0] rfRdAddr,
    input wire logic [31:0] rfRdData,
    output logic rfWrEn,
    output logic [3:0] rfWrAddr,
    output logic [31:0] rfWrData,
    output logic rfUserBank,
    output logic statusRestore,
    output logic abortTrap
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] countSet(input logic [15:0] list);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i <= mts_pkg::LIST_HI; i++) begin
            n = n + {4'h0, list[i]};
        end
        return n;
    endfunction

    function automatic logic [3:0] lowestSet(input logic [15:0] list);
        logic [3:0] r;
        r = 4'h0;
        for (int i = mts_pkg::LIST_HI; i >= 0; i--) begin
            if (list[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mts_pkg::state_e state;
    mts_pkg::state_e next_state;
    logic [31:0] instr;
    logic [31:0] instrAddr;
    logic doneFlag;
    logic abortFlag;
    logic badOp;
    logic [31:0] faultAddr;
    logic [3:0] faultCause;
    logic [31:0] abortLink;
    logic [31:0] baseOrig;
    logic [31:0] baseNew;
    logic [31:0] curAddr;
    logic [15:0] remList;
    logic firstXfer;
    logic aborted;
    logic pendValid;
    logic [3:0] pendReg;
    logic [31:0] pendData;
    logic [1:0] pcFetchCnt;
    logic [31:0] swpData;
    logic [31:0] addrHist1;
    logic [31:0] addrHist2;
    logic extSync1;
    logic extSync2;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic isBlock;
    logic isSwap;
    logic isLoad;
    logic [3:0] baseField;
    logic [15:0] regList;
    logic [4:0] regCount;
    logic [31:0] span;
    logic [3:0] curReg;
    logic lastXfer;
    logic dataCycle;
    logic abortNow;
    logic anyAbort;
    logic apbWrite;
    logic startReq;
    logic pcWriteNow;
    logic restoreNow;
    logic swapDestNow;
    logic endNow;

    assign isBlock = instr[mts_pkg::CLASS_HI:mts_pkg::BLOCK_LO] == mts_pkg::BLOCK_CLASS;
    assign isSwap = instr[mts_pkg::CLASS_HI:mts_pkg::SWAP_LO] == mts_pkg::SWAP_CLASS
        && instr[mts_pkg::MARK_HI:mts_pkg::MARK_LO] == mts_pkg::SWAP_MARK;
    assign isLoad = instr[mts_pkg::BIT_L];
    assign baseField = instr[mts_pkg::BASE_HI:mts_pkg::BASE_LO];
    assign regList = instr[mts_pkg::LIST_HI:0]; // RL24
    assign regCount = countSet(regList);
    assign span = {25'h0, regCount, 2'b00};
    assign curReg = lowestSet(remList); // RL23
    assign lastXfer = (remList & (remList - 16'h0001)) == 16'h0000;
    assign dataCycle = state == mts_pkg::ST_XFER || state == mts_pkg::ST_SWPRD
        || state == mts_pkg::ST_SWPWR;
    // the pin abort lands two cycles late; it still counts until the sequence ends
    assign abortNow = (dataCycle && mmuAbort)
        || (state != mts_pkg::ST_IDLE && state != mts_pkg::ST_FETCH && extSync2); // RL4
    assign anyAbort = aborted || abortNow;
    assign apbWrite = psel && penable && pwrite;
    assign startReq = apbWrite && paddr == mts_pkg::OFF_CTRL && pwdata[mts_pkg::CTRL_START]
        && state == mts_pkg::ST_IDLE;
    assign pcWriteNow = pendValid && !abortNow && pendReg == mts_pkg::PC_REG;
    assign restoreNow = state == mts_pkg::ST_INTERNAL && isBlock && isLoad && anyAbort;
    assign swapDestNow = state == mts_pkg::ST_INTERNAL && isSwap && !anyAbort;
    assign endNow = (state == mts_pkg::ST_INTERNAL && !pcWriteNow)
        || (state == mts_pkg::ST_PCFETCH && pcFetchCnt == 2'h1);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            mts_pkg::ST_IDLE: begin
                if (startReq && (isBlock || isSwap)) begin
                    next_state = mts_pkg::ST_FETCH; // RL14
                end
            end
            mts_pkg::ST_FETCH: begin
                next_state = isSwap ? mts_pkg::ST_SWPRD : mts_pkg::ST_XFER; // RL22
            end
            mts_pkg::ST_XFER: begin
                if (lastXfer) begin
                    next_state = mts_pkg::ST_INTERNAL; // RL6 RL13
                end
            end
            mts_pkg::ST_SWPRD: next_state = mts_pkg::ST_SWPWR; // RL17
            mts_pkg::ST_SWPWR: next_state = mts_pkg::ST_INTERNAL;
            mts_pkg::ST_INTERNAL: begin
                next_state = pcWriteNow ? mts_pkg::ST_PCFETCH : mts_pkg::ST_IDLE; // RL14
            end
            mts_pkg::ST_PCFETCH: begin
                if (pcFetchCnt == 2'h1) begin
                    next_state = mts_pkg::ST_IDLE;
                end
            end
            default: next_state = mts_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= mts_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pcFetchCnt <= 2'h0;
        end else if (state == mts_pkg::ST_INTERNAL) begin
            pcFetchCnt <= mts_pkg::PC_EXTRA_FETCHES;
        end else if (state == mts_pkg::ST_PCFETCH) begin
            pcFetchCnt <= pcFetchCnt - 2'h1;
        end
    end

    // ------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            baseOrig <= 32'h0;
            baseNew <= 32'h0;
            curAddr <= 32'h0;
            remList <= 16'h0;
            firstXfer <= 1'b0;
        end else if (state == mts_pkg::ST_FETCH) begin
            baseOrig <= rfRdData;
            remList <= regList;
            firstXfer <= 1'b1;
            if (isSwap) begin
                curAddr <= rfRdData; // RL18
            end else if (instr[mts_pkg::BIT_U]) begin
                baseNew <= rfRdData + span;
                curAddr <= instr[mts_pkg::BIT_P] ? rfRdData + mts_pkg::WORD_STEP
                                                 : rfRdData; // RL15
            end else begin
                baseNew <= rfRdData - span;
                curAddr <= instr[mts_pkg::BIT_P] ? rfRdData - span
                                                 : rfRdData - span + mts_pkg::WORD_STEP; // RL15
            end
        end else if (state == mts_pkg::ST_XFER) begin
            curAddr <= curAddr + mts_pkg::WORD_STEP; // RL25
            remList <= remList & ~(16'h0001 << curReg);
            firstXfer <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // memory side
    // ------------------------------------------------------------
    logic [31:0] storeData;

    always_comb begin
        if (curReg == mts_pkg::PC_REG) begin
            storeData = instrAddr + mts_pkg::PC_STORE_OFFSET;
        end else if (curReg == baseField && !firstXfer && instr[mts_pkg::BIT_W]) begin
            storeData = baseNew; // RL2
        end else begin
            storeData = rfRdData; // RL2
        end
    end

    always_comb begin
        rfRdAddr = baseField;
        memWdata = 32'h0;
        if (state == mts_pkg::ST_XFER && !isLoad) begin
            rfRdAddr = curReg;
            memWdata = storeData;
        end else if (state == mts_pkg::ST_SWPWR) begin
            rfRdAddr = instr[mts_pkg::SRC_HI:mts_pkg::SRC_LO];
            // byte lane replicated so either endian picks it up
            memWdata = instr[mts_pkg::BIT_B] ? {4{rfRdData[7:0]}} : rfRdData; // RL21
        end
    end

    assign memReq = dataCycle;
    assign memWrite = (state == mts_pkg::ST_XFER && !isLoad) || state == mts_pkg::ST_SWPWR;
    assign memByte = isSwap && instr[mts_pkg::BIT_B] && dataCycle; // RL21
    assign memAddr = dataCycle ? curAddr : instrAddr;
    assign busLock = state == mts_pkg::ST_SWPRD || state == mts_pkg::ST_SWPWR; // RL19 RL20
    assign intBlock = state != mts_pkg::ST_IDLE; // RL17
    assign fetchReq = state == mts_pkg::ST_FETCH || state == mts_pkg::ST_PCFETCH; // RL14
    assign rfUserBank = isBlock && instr[mts_pkg::BIT_S] && privMode
        && (!isLoad || !regList[mts_pkg::LIST_HI]) && state != mts_pkg::ST_IDLE; // RL16

    // ------------------------------------------------------------
    // load pipeline: a read is written one cycle later
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pendValid <= 1'b0;
            pendReg <= 4'h0;
            pendData <= 32'h0;
        end else begin
            pendValid <= state == mts_pkg::ST_XFER && isLoad && !anyAbort; // RL9 RL11
            pendReg <= curReg;
            pendData <= memRdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            swpData <= 32'h0;
        end else if (state == mts_pkg::ST_SWPRD) begin
            swpData <= instr[mts_pkg::BIT_B] ? memRdata & mts_pkg::BYTE_MASK : memRdata;
        end
    end

    // ------------------------------------------------------------
    // register file write port
    // ------------------------------------------------------------
    always_comb begin
        rfWrEn = 1'b0;
        rfWrAddr = baseField;
        rfWrData = baseNew;
        if (restoreNow) begin
            rfWrEn = 1'b1;
            rfWrData = instr[mts_pkg::BIT_W] ? baseNew : baseOrig; // RL12
        end else if (swapDestNow) begin
            rfWrEn = 1'b1;
            rfWrAddr = instr[mts_pkg::DEST_HI:mts_pkg::DEST_LO];
            rfWrData = swpData; // RL18
        end else if (pendValid && !abortNow) begin
            // later than the write-back, so a listed base ends up loaded
            rfWrEn = 1'b1;
            rfWrAddr = pendReg; // RL3 RL10
            rfWrData = pendData;
        end else if (state == mts_pkg::ST_XFER && firstXfer && instr[mts_pkg::BIT_W]) begin
            rfWrEn = 1'b1; // RL1 RL7
        end
    end

    assign statusRestore = pcWriteNow && instr[mts_pkg::BIT_S]; // RL16

    // ------------------------------------------------------------
    // abort capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            addrHist1 <= 32'h0;
            addrHist2 <= 32'h0;
        end else begin
            extSync1 <= extAbort;
            extSync2 <= extSync1;
            addrHist1 <= memAddr;
            addrHist2 <= addrHist1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aborted <= 1'b0;
            faultAddr <= 32'h0;
            faultCause <= 4'h0;
        end else if (state == mts_pkg::ST_FETCH) begin
            aborted <= 1'b0;
        end else if (abortNow && !aborted) begin
            aborted <= 1'b1;
            // the pin is two stages late, so its address is two cycles old
            faultAddr <= (dataCycle && mmuAbort) ? curAddr : addrHist2; // RL5
            faultCause <= (dataCycle && mmuAbort) ? mts_pkg::CAUSE_MMU
                                                  : mts_pkg::CAUSE_EXT; // RL5
        end
    end

    assign abortTrap = endNow && anyAbort; // RL6 RL13

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            abortLink <= 32'h0;
        end else if (abortTrap) begin
            abortLink <= instrAddr + mts_pkg::LINK_OFFSET; // RL5
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic mapped;

    assign mapped = paddr == mts_pkg::OFF_CTRL || paddr == mts_pkg::OFF_INSTR
        || paddr == mts_pkg::OFF_IADDR || paddr == mts_pkg::OFF_STATUS
        || paddr == mts_pkg::OFF_FADDR || paddr == mts_pkg::OFF_FCAUSE
        || paddr == mts_pkg::OFF_ALINK;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        prdata = 32'h0;
        if (psel && penable && !pwrite) begin
            case (paddr)
                mts_pkg::OFF_INSTR: prdata = instr;
                mts_pkg::OFF_IADDR: prdata = instrAddr;
                mts_pkg::OFF_STATUS: prdata = {28'h0, badOp, abortFlag, doneFlag,
                                               state != mts_pkg::ST_IDLE};
                mts_pkg::OFF_FADDR: prdata = faultAddr;
                mts_pkg::OFF_FCAUSE: prdata = {28'h0, faultCause};
                mts_pkg::OFF_ALINK: prdata = abortLink;
                default: prdata = 32'h0;
            endcase
        end
    end

    // operands are frozen while a sequence runs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            instr <= 32'h0;
            instrAddr <= 32'h0;
        end else if (apbWrite && state == mts_pkg::ST_IDLE) begin
            if (paddr == mts_pkg::OFF_INSTR) begin
                instr <= pwdata;
            end
            if (paddr == mts_pkg::OFF_IADDR) begin
                instrAddr <= pwdata;
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            doneFlag <= 1'b0;
            abortFlag <= 1'b0;
            badOp <= 1'b0;
        end else begin
            if (endNow) begin
                doneFlag <= 1'b1;
            end else if (apbWrite && paddr == mts_pkg::OFF_STATUS && pwdata[mts_pkg::STAT_DONE]) begin
                doneFlag <= 1'b0;
            end
            if (abortTrap) begin
                abortFlag <= 1'b1;
            end else if (apbWrite && paddr == mts_pkg::OFF_STATUS
                         && pwdata[mts_pkg::STAT_ABORT]) begin
                abortFlag <= 1'b0;
            end
            if (startReq && !isBlock && !isSwap) begin
                badOp <= 1'b1;
            end else if (apbWrite && paddr == mts_pkg::OFF_STATUS
                         && pwdata[mts_pkg::STAT_BADOP]) begin
                badOp <= 1'b0;
            end
        end
    end

endmodule

/* verification/mts_properties.sv */
`timescale 1ns/10ps
module mts_properties (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic busLock,
    input wire logic intBlock,
    input wire logic fetchReq,
    input wire logic rfWrEn,
    input wire logic [3:0] rfWrAddr,
    input wire logic statusRestore,
    input wire logic abortTrap
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ----------------
    // sequences
    // ----------------
    sequence swRd;
        memReq && busLock && !memWrite;
    endsequence
    sequence swWr;
        memReq && busLock && memWrite;
    endsequence
    sequence blk2;
        (memReq && !busLock) ##1 (memReq && !busLock);
    endsequence
    chk_swap_pair: assert property (swRd |=> swWr)
        else $error("swap read without locked write");
    chk_swap_addr: assert property (swRd ##1 swWr |-> memAddr == $past(memAddr))
        else $error("swap write address moved");
    chk_swap_end: assert property (swRd ##1 swWr |=> !memReq && !busLock && intBlock)
        else $error("swap internal cycle missing");
    chk_lock_data: assert property (busLock |-> memReq && intBlock && !fetchReq)
        else $error("lock outside swap data cycle");
    chk_block_step: assert property (blk2 |->
        (memAddr - $past(memAddr) == 32'h4) || ($past(memAddr) - memAddr == 32'h4))
        else $error("block address step wrong");
    chk_fetch_first: assert property ($rose(intBlock) |-> fetchReq)
        else $error("sequence not opened by fetch");
    chk_status_pc: assert property (statusRestore |-> rfWrEn && rfWrAddr == mts_pkg::PC_REG)
        else $error("status restore without pc load");
    chk_trap_end: assert property (abortTrap |=> !intBlock)
        else $error("trap before sequence end");
endmodule
bind multi_transfer_swap_sequencer mts_properties chk (.clk, .arst_n, .memReq, .memWrite,
    .memAddr, .busLock, .intBlock, .fetchReq, .rfWrEn, .rfWrAddr, .statusRestore, .abortTrap);

/* verification/mts_memory_model.sv */
`timescale 1ns/10ps
module mts_memory_model (
    input wire logic clk,
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memByte,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic [31:0] memRdata,
    output logic mmuAbort,
    output logic extAbort,
    input wire logic [3:0] rfRdAddr,
    output logic [31:0] rfRdData,
    input wire logic rfWrEn,
    input wire logic [3:0] rfWrAddr,
    input wire logic [31:0] rfWrData,
    input wire logic abortOn,
    input wire logic abortExt,
    input wire logic [31:0] abortAt
);
    // ----------------
    // memory and registers
    // ----------------
    logic [31:0] mem [256];
    logic [31:0] regs [16];
    logic [31:0] lastRd = 32'h0;
    logic hit;
    assign hit = memReq && abortOn && memAddr == abortAt;
    assign mmuAbort = hit && !abortExt;
    assign extAbort = hit && abortExt;
    // idle bus shows the inverse, so stale data cannot pass
    assign memRdata = memReq ? mem[memAddr[9:2]] : ~lastRd;
    assign rfRdData = regs[rfRdAddr];
    // never arbitrates, so a locked pair is never split
    always @(posedge clk) begin
        if (memReq && !memWrite) begin
            lastRd <= memRdata;
        end
        if (memReq && memWrite && !hit) begin
            mem[memAddr[9:2]] <= memByte ? {mem[memAddr[9:2]][31:8], memWdata[7:0]} : memWdata;
        end
        if (rfWrEn) begin
            regs[rfWrAddr] <= rfWrData;
        end
    end
endmodule

/* verification/multi_transfer_swap_sequencer_tb.sv */
`timescale 1ns/10ps
module multi_transfer_swap_sequencer_tb;
    localparam logic [31:0] IADDR = 32'h00000400;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic privMode = 1'b1, abortOn = 1'b0, abortExt = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, abortAt = 32'h0, rd;
    logic [31:0] prdata, memAddr, memWdata, memRdata, rfRdData, rfWrData;
    logic pready, pslverr, memReq, memWrite, memByte, mmuAbort, extAbort, busLock;
    logic intBlock, fetchReq, rfWrEn, rfUserBank, statusRestore, abortTrap;
    logic [3:0] rfRdAddr, rfWrAddr;
    int mismatches = 0, checks = 0, nData = 0, nFetch = 0, f0, d0;
    int off[4] = '{-1, 0, -2, 1};
    multi_transfer_swap_sequencer uut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .privMode, .memReq, .memWrite, .memByte,
        .memAddr, .memWdata, .memRdata, .mmuAbort, .extAbort, .busLock, .intBlock,
        .fetchReq, .rfRdAddr, .rfRdData, .rfWrEn, .rfWrAddr, .rfWrData, .rfUserBank,
        .statusRestore, .abortTrap);
    mts_memory_model pm (.clk, .memReq, .memWrite, .memByte, .memAddr, .memWdata,
        .memRdata, .mmuAbort, .extAbort, .rfRdAddr, .rfRdData, .rfWrEn, .rfWrAddr,
        .rfWrData, .abortOn, .abortExt, .abortAt);
    always #20 clk = ~clk;
    always @(posedge clk) begin
        nData <= nData + int'(memReq);
        nFetch <= nFetch + int'(fetchReq);
    end
    // ----------------
    // tasks
    // ----------------
    task automatic close_out;
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input logic hung);
        if (hung) begin
            mismatches++;
            $display("Error %0t: timeout", $time);
            close_out();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        bound(pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic init;
        for (int i = 0; i < 16; i++) begin
            pm.regs[i] = 32'(i * 16);
        end
        for (int j = 0; j < 256; j++) begin
            pm.mem[j] = 32'ha000 + 32'(j);
        end
    endtask
    task automatic run(input logic [31:0] ins);
        int n;
        apb(1'b1, mts_pkg::OFF_STATUS, 32'h0000000e);
        apb(1'b1, mts_pkg::OFF_INSTR, ins);
        apb(1'b1, mts_pkg::OFF_IADDR, IADDR);
        f0 = nFetch;
        d0 = nData;
        apb(1'b1, mts_pkg::OFF_CTRL, 32'h00000001);
        n = 0;
        do begin
            apb(1'b0, mts_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (rd[mts_pkg::STAT_DONE] !== 1'b1 && n < 40);
        bound(rd[mts_pkg::STAT_DONE] !== 1'b1);
    endtask
    function automatic logic [31:0] blk(input logic [3:0] pusw, input logic l,
        input logic [3:0] b, input logic [15:0] lst);
        return {4'he, 3'b100, pusw, l, b, lst};
    endfunction
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rdchk(mts_pkg::OFF_STATUS, 32'h0);
        rdchk(12'h0fc, 32'h0);
        chk(32'(err), 32'h1);
        init();
        run(blk(4'b0101, 1'b0, 4'h1, 16'h0006));
        chk(pm.mem[4], 32'h10);
        chk(pm.mem[5], 32'h20);
        chk(pm.regs[1], 32'h18);
        chk(32'(nData - d0), 32'h2);
        init();
        run(blk(4'b0101, 1'b0, 4'h2, 16'h0006));
        chk(pm.mem[9], 32'h28);
        for (int m = 0; m < 4; m++) begin
            init();
            run(blk({m[1:0], 2'b00}, 1'b1, 4'h3, 16'h0030));
            chk(pm.regs[4], 32'ha000 + 32'(12 + off[m]));
            chk(pm.regs[5], 32'ha000 + 32'(13 + off[m]));
        end
        init();
        run(blk(4'b0101, 1'b1, 4'h6, 16'h00c0));
        chk(pm.regs[6], 32'ha018);
        // abort on the second word of a load
        init();
        abortAt <= 32'h84;
        abortOn <= 1'b1;
        run(blk(4'b0101, 1'b1, 4'h8, 16'h0700));
        chk(rd, 32'h6);
        chk(pm.regs[8], 32'h8c);
        chk(pm.regs[9], 32'h90);
        rdchk(mts_pkg::OFF_FADDR, 32'h84);
        rdchk(mts_pkg::OFF_FCAUSE, 32'(mts_pkg::CAUSE_MMU));
        rdchk(mts_pkg::OFF_ALINK, IADDR + 32'h8);
        init();
        abortAt <= 32'hc0;
        abortExt <= 1'b1;
        run(blk(4'b0101, 1'b0, 4'hc, 16'h0003));
        chk(pm.mem[49], 32'h10);
        chk(pm.regs[12], 32'hc8);
        rdchk(mts_pkg::OFF_FCAUSE, 32'(mts_pkg::CAUSE_EXT));
        rdchk(mts_pkg::OFF_FADDR, 32'hc0);
        abortOn <= 1'b0;
        init();
        run(blk(4'b0110, 1'b1, 4'hb, 16'h8000));
        chk(pm.regs[15], 32'ha02c);
        chk(32'(nFetch - f0), 32'h3);
        for (int b = 0; b < 2; b++) begin
            init();
            run({4'he, 5'b00010, b[0], 2'b00, 4'h4, 4'h2, 8'h09, 4'h3});
            chk(pm.regs[2], b ? 32'h10 : 32'ha010);
            chk(pm.mem[16], b ? 32'ha030 : 32'h30);
            chk(32'(nData - d0), 32'h2);
        end
        close_out();
    end
endmodule
